// ---- design/cord_top.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Codes 0,1,2 give divide by 1,2,3.
// - Other codes divide by sixteen times code bits 4:0 plus two.
// - Eight bit divider field, reset code five.
// - Twelve bit TX divider split high/low.
// - TX divider resets to 0x1F4.
// - Twelve bit RX divider, reset 0x014.
// - Seven bit RX factor, bit seven reserved.
// - Factor zero is used as 128.
// - Two bit settle select picks wait time.
// - Wait applies at start-up and sleep exit.
module cord_top
   import cord_pkg::*;
#(
   parameter int WAIT_00 = WAIT_CYC_00,
   parameter int WAIT_01 = WAIT_CYC_01,
   parameter int WAIT_10 = WAIT_CYC_10,
   parameter int WAIT_11 = WAIT_CYC_11
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic master_clk_i,
   input wire logic sleep_i,
   output logic clock_ready_o,
   output logic external_clock_output_o,
   output cord_rates_t rates_o
);
   localparam int NUM_REGS = 8;

   logic [7:0] regs [1:8];
   logic wr_hit;
   logic rd_hit;
   logic sleep_s1;
   logic sleep_s2;
   logic mclk_s1;
   logic mclk_s2;
   logic mclk_d;
   logic mclk_rise;
   logic [11:0] tx_divider;
   logic [11:0] rx_divider;
   logic [7:0] factor_value;
   logic [15:0] wait_cnt;
   logic [15:0] wait_len;
   logic wait_done;
   logic settling;
   logic [8:0] div_cnt;
   logic [8:0] next_div_cnt;
   logic [8:0] div_period;
   logic [8:0] high_len;
   logic div_wrap;
   logic next_clock_out;

   // Offset check shared by the read and write decode.
   function automatic logic addr_mapped(input logic [3:0] addr);
      return (addr >= ADDR_CLOCK_OUTPUT_DIVIDER) && (addr <= ADDR_OSC_SETTLE_WAIT);
   endfunction

   function automatic logic [7:0] reg_reset(input logic [3:0] addr);
      logic [7:0] value;
      value = 8'h00;
      case (addr)
         ADDR_CLOCK_OUTPUT_DIVIDER: value = RST_CLOCK_OUTPUT_DIVIDER;
         ADDR_TX_RATE_DIVIDER_HIGH: value = RST_TX_RATE_DIVIDER_HIGH;
         ADDR_TX_RATE_DIVIDER_LOW: value = RST_TX_RATE_DIVIDER_LOW;
         ADDR_RX_RATE_DIVIDER_HIGH: value = RST_RX_RATE_DIVIDER_HIGH;
         ADDR_RX_RATE_DIVIDER_LOW: value = RST_RX_RATE_DIVIDER_LOW;
         ADDR_RX_RATE_FACTOR: value = RST_RX_RATE_FACTOR;
         ADDR_RESERVED_SEVEN: value = RST_RESERVED_SEVEN;
         ADDR_OSC_SETTLE_WAIT: value = RST_OSC_SETTLE_WAIT;
         default: value = 8'h00;
      endcase
      return value;
   endfunction

   // Join a high nibble and a low byte into one divider.
   function automatic logic [11:0] rate_join(input logic [7:0] high, input logic [7:0] low);
      return {high[RATE_HIGH_MSB:0], low};
   endfunction

   // Write decode.
   always_comb begin
      wr_hit = wr_i && addr_mapped(addr_i);
   end

   // Read decode.
   always_comb begin
      rd_hit = rd_i && addr_mapped(addr_i);
   end

   for (genvar g = 1; g <= NUM_REGS; g++) begin : g_reg
      localparam logic [3:0] OFFSET = 4'(g);
      localparam logic [7:0] RESET_VALUE = reg_reset(OFFSET);

      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            regs[g] <= RESET_VALUE;
         end else if (wr_hit && (addr_i == OFFSET)) begin
            regs[g] <= wdata_i;
         end
      end
   end

   // Read data stands for one cycle only.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_hit) begin
         rdata_o <= regs[addr_i];
      end else begin
         rdata_o <= 8'h00;
      end
   end

   always_comb begin
      tx_divider = rate_join(regs[ADDR_TX_RATE_DIVIDER_HIGH], regs[ADDR_TX_RATE_DIVIDER_LOW]);
      rx_divider = rate_join(regs[ADDR_RX_RATE_DIVIDER_HIGH], regs[ADDR_RX_RATE_DIVIDER_LOW]);
   end

   always_comb begin
      if (regs[ADDR_RX_RATE_FACTOR][FACTOR_MSB:0] == '0) begin
         factor_value = FACTOR_ZERO_AS;
      end else begin
         factor_value = {1'b0, regs[ADDR_RX_RATE_FACTOR][FACTOR_MSB:0]};
      end
   end

   // Rate outputs follow the registers.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rates_o <= '0;
      end else begin
         rates_o.tx_rate_divider <= tx_divider;
         rates_o.rx_rate_divider <= rx_divider;
         rates_o.rx_rate_factor <= factor_value;
      end
   end

   // Sleep synchroniser, held asleep in reset.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sleep_s1 <= 1'b1;
         sleep_s2 <= 1'b1;
      end else begin
         sleep_s1 <= sleep_i;
         sleep_s2 <= sleep_s1;
      end
   end

   // Master clock synchroniser.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mclk_s1 <= 1'b0;
         mclk_s2 <= 1'b0;
      end else begin
         mclk_s1 <= master_clk_i;
         mclk_s2 <= mclk_s1;
      end
   end

   // Master clock history for edge detection.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mclk_d <= 1'b0;
      end else begin
         mclk_d <= mclk_s2;
      end
   end

   always_comb begin
      mclk_rise = mclk_s2 && !mclk_d;
   end

   always_comb begin
      case (regs[ADDR_OSC_SETTLE_WAIT][OSC_SEL_LSB +: OSC_SEL_WIDTH])
         2'h0: begin
            wait_len = 16'(WAIT_00);
         end
         2'h1: begin
            wait_len = 16'(WAIT_01);
         end
         2'h2: begin
            wait_len = 16'(WAIT_10);
         end
         default: begin
            wait_len = 16'(WAIT_11);
         end
      endcase
   end

   always_comb begin
      wait_done = (wait_cnt + 16'h0001) >= wait_len;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_cnt <= 16'h0000;
      end else if (sleep_s2) begin
         wait_cnt <= 16'h0000;
      end else if (settling) begin
         wait_cnt <= wait_cnt + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         settling <= 1'b1;
      end else if (sleep_s2) begin
         settling <= 1'b1;
      end else if (settling && wait_done) begin
         settling <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clock_ready_o <= 1'b0;
      end else if (sleep_s2) begin
         clock_ready_o <= 1'b0;
      end else if (settling && wait_done) begin
         clock_ready_o <= 1'b1;
      end
   end

   always_comb begin
      case (regs[ADDR_CLOCK_OUTPUT_DIVIDER])
         DIV_CODE_24: begin
            div_period = DIV_PERIOD_24;
         end
         DIV_CODE_12: begin
            div_period = DIV_PERIOD_12;
         end
         DIV_CODE_8: begin
            div_period = DIV_PERIOD_8;
         end
         default: begin
            div_period = {regs[ADDR_CLOCK_OUTPUT_DIVIDER][DIV_CODE_MSB:0], DIV_STEP_ZEROS}
                         + DIV_PERIOD_OFFSET;
         end
      endcase
   end

   always_comb begin
      high_len = div_period >> 1;
   end

   // The period ends on this edge.
   always_comb begin
      div_wrap = (div_cnt + 9'h001) >= div_period;
   end

   // Next counter and output level.
   always_comb begin
      if (div_wrap) begin
         next_div_cnt = 9'h000;
      end else begin
         next_div_cnt = div_cnt + 9'h001;
      end
      next_clock_out = div_wrap || ((div_cnt + 9'h001) < high_len);
   end

   // Count synchronised master clock edges.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt <= 9'h000;
      end else if (!clock_ready_o) begin
         div_cnt <= 9'h000;
      end else if ((div_period != DIV_PERIOD_24) && mclk_rise) begin
         div_cnt <= next_div_cnt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         external_clock_output_o <= 1'b0;
      end else if (!clock_ready_o) begin
         external_clock_output_o <= 1'b0;
      end else if (div_period == DIV_PERIOD_24) begin
         external_clock_output_o <= mclk_s2;
      end else if (mclk_rise) begin
         external_clock_output_o <= next_clock_out;
      end
   end
endmodule

// ---- design/cord_pkg.sv ----
package cord_pkg;
   localparam logic [3:0] ADDR_CLOCK_OUTPUT_DIVIDER = 4'h1;
   localparam logic [3:0] ADDR_TX_RATE_DIVIDER_HIGH = 4'h2;
   localparam logic [3:0] ADDR_TX_RATE_DIVIDER_LOW = 4'h3;
   localparam logic [3:0] ADDR_RX_RATE_DIVIDER_HIGH = 4'h4;
   localparam logic [3:0] ADDR_RX_RATE_DIVIDER_LOW = 4'h5;
   localparam logic [3:0] ADDR_RX_RATE_FACTOR = 4'h6;
   localparam logic [3:0] ADDR_RESERVED_SEVEN = 4'h7;
   localparam logic [3:0] ADDR_OSC_SETTLE_WAIT = 4'h8;
   localparam logic [7:0] RST_CLOCK_OUTPUT_DIVIDER = 8'h05;
   localparam logic [7:0] RST_TX_RATE_DIVIDER_HIGH = 8'h01;
   localparam logic [7:0] RST_TX_RATE_DIVIDER_LOW = 8'hF4;
   localparam logic [7:0] RST_RX_RATE_DIVIDER_HIGH = 8'h00;
   localparam logic [7:0] RST_RX_RATE_DIVIDER_LOW = 8'h14;
   localparam logic [7:0] RST_RX_RATE_FACTOR = 8'h7D;
   localparam logic [7:0] RST_RESERVED_SEVEN = 8'hFE;
   localparam logic [7:0] RST_OSC_SETTLE_WAIT = 8'h40;
   localparam int OSC_SEL_LSB = 5;
   localparam int CLK_MHZ = 100;
   localparam int WAIT_US_00 = 500;
   localparam int WAIT_US_01 = 250;
   localparam int WAIT_US_10 = 50;
   localparam int WAIT_US_11 = 10;
   localparam int WAIT_CYC_00 = WAIT_US_00 * CLK_MHZ;
   localparam int WAIT_CYC_01 = WAIT_US_01 * CLK_MHZ;
   localparam int WAIT_CYC_10 = WAIT_US_10 * CLK_MHZ;
   localparam int WAIT_CYC_11 = WAIT_US_11 * CLK_MHZ;
   localparam logic [7:0] DIV_CODE_24 = 8'h00;
   localparam logic [7:0] DIV_CODE_12 = 8'h01;
   localparam logic [7:0] DIV_CODE_8 = 8'h02;
   localparam logic [7:0] FACTOR_ZERO_AS = 8'h80;
   localparam int OSC_SEL_WIDTH = 2;
   localparam int RATE_HIGH_MSB = 3;
   localparam int FACTOR_MSB = 6;
   localparam int DIV_CODE_MSB = 4;
   localparam logic [3:0] DIV_STEP_ZEROS = 4'h0;
   localparam logic [8:0] DIV_PERIOD_24 = 9'h001;
   localparam logic [8:0] DIV_PERIOD_12 = 9'h002;
   localparam logic [8:0] DIV_PERIOD_8 = 9'h003;
   localparam logic [8:0] DIV_PERIOD_OFFSET = 9'h002;
   typedef struct packed {
      logic [11:0] tx_rate_divider;
      logic [11:0] rx_rate_divider;
      logic [7:0] rx_rate_factor;
   } cord_rates_t;
endpackage

// ---- verification/cord_checker.sv ----
`timescale 1ns/1ps
module cord_checker
   import cord_pkg::*;
#(parameter int WAIT_00 = 0, WAIT_01 = 0, WAIT_10 = 0, WAIT_11 = 0) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic sleep_i,
   input wire logic clock_ready_o,
   input wire logic external_clock_output_o,
   input wire cord_rates_t rates_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   wire logic [15:0] wa = {15'h0, wr_i} << addr_i;
   a_tx_high: assert property (wa[2] ##1 !wa[2] |=>
      rates_o.tx_rate_divider[11:8] == $past(wdata_i[3:0], 2)) else $error("tx high");
   a_tx_low: assert property (wa[3] ##1 !wa[3] |=>
      rates_o.tx_rate_divider[7:0] == $past(wdata_i, 2)) else $error("tx low");
   a_rx_low: assert property (wa[5] ##1 !wa[5] |=>
      rates_o.rx_rate_divider[7:0] == $past(wdata_i, 2)) else $error("rx low");
   a_factor_zero: assert property (wa[6] && wdata_i[6:0] == 7'h00 ##1 !wa[6] |=>
      rates_o.rx_rate_factor == FACTOR_ZERO_AS) else $error("factor");
   a_reserved_store: assert property (wa[7] ##1 rd_i && addr_i == 4'h7 |=>
      rdata_o == $past(wdata_i, 2)) else $error("reserved");
   a_clock_gated: assert property (!clock_ready_o [*2] |->
      !external_clock_output_o) else $error("gated");
   a_sleep_stops: assert property (sleep_i [*5] |-> !clock_ready_o) else $error("sleep");
   a_wake_wait: assert property ($fell(sleep_i) |=> !clock_ready_o [*6]) else $error("wake");
   cover property ($rose(clock_ready_o));
   cover property ($rose(external_clock_output_o));
   cover property (rd_i ##1 rdata_o != 8'h00);
endmodule
bind cord_top cord_checker #(.WAIT_00(WAIT_00), .WAIT_01(WAIT_01), .WAIT_10(WAIT_10),
   .WAIT_11(WAIT_11)) u_chk (.*);

// ---- verification/cord_top_tb.sv ----
`timescale 1ns/1ps
module cord_top_tb;
   import cord_pkg::*;
   logic sys_clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, master_clk_i = 0, sleep_i = 0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, d;
   logic clock_ready_o, external_clock_output_o;
   cord_rates_t rates_o;
   int num_errors = 0, check_count = 0, n, p;
   realtime t0;
   logic [19:0] rows [8] = '{20'h105A7, 20'h201F3, 20'h3F45A, 20'h4009C, 20'h5143C,
      20'h67D9E, 20'h7FE01, 20'h84075};
   int waits [4] = '{40, 20, 10, 6};
   cord_top #(.WAIT_00(40), .WAIT_01(20), .WAIT_10(10), .WAIT_11(6)) dut (.*);
   always #5 sys_clk_i = ~sys_clk_i;
   always #20 master_clk_i = ~master_clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      d = rdata_o;
      @(posedge sys_clk_i);
   endtask
   task automatic settle(input int w);
      n = 0;
      while (clock_ready_o !== 1'b1) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk(n >= w && n <= w + 6, 1);
   endtask
   task automatic summarize;
      if (num_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      settle(10);
      foreach (rows[i]) begin
         rd(rows[i][19:16]);
         chk(d, rows[i][15:8]);
         wr(rows[i][19:16], rows[i][7:0]);
         rd(rows[i][19:16]);
         chk(d, rows[i][7:0]);
      end
      chk(rates_o.tx_rate_divider, 12'h35A);
      chk(rates_o.rx_rate_divider, 12'hC3C);
      rd(4'h9);
      chk(d, 8'h00);
      wr(ADDR_RX_RATE_FACTOR, 8'h80);
      repeat (2) @(posedge sys_clk_i);
      chk(rates_o.rx_rate_factor, FACTOR_ZERO_AS);
      wr(ADDR_TX_RATE_DIVIDER_HIGH, 8'h01);
      rd(ADDR_RX_RATE_FACTOR);
      chk(d, 8'h80);
      wr(ADDR_TX_RATE_DIVIDER_LOW, 8'hF4);
      rd(ADDR_TX_RATE_DIVIDER_HIGH);
      chk(d, 8'h01);
      wr(ADDR_RX_RATE_FACTOR, 8'h7D);
      rd(ADDR_TX_RATE_DIVIDER_LOW);
      chk(d, 8'hF4);
      wr(ADDR_RX_RATE_DIVIDER_HIGH, 8'h00);
      rd(ADDR_RX_RATE_FACTOR);
      chk(d, 8'h7D);
      wr(ADDR_RX_RATE_DIVIDER_LOW, 8'h28);
      rd(ADDR_RX_RATE_DIVIDER_HIGH);
      chk(d, 8'h00);
      chk(rates_o.tx_rate_divider, 12'(24000000 / 10 / 4800));
      chk(rates_o.rx_rate_divider, 12'(24000000 / (4800 * 125)));
      chk(rates_o.rx_rate_factor, 8'h7D);
      foreach (waits[c]) begin
         wr(ADDR_CLOCK_OUTPUT_DIVIDER, 8'(c));
         p = (c < 3) ? c + 1 : 16 * c + 2;
         repeat (3) @(posedge external_clock_output_o);
         t0 = $realtime;
         @(negedge external_clock_output_o);
         if (c == 2) chk(int'($realtime - t0), 40);
         @(posedge external_clock_output_o);
         chk(int'($realtime - t0), p * 40);
      end
      foreach (waits[c]) begin
         wr(ADDR_OSC_SETTLE_WAIT, {1'b0, 2'(c), 5'h00});
         sleep_i <= 1'b1;
         repeat (8) @(posedge sys_clk_i);
         chk(clock_ready_o, 1'b0);
         sleep_i <= 1'b0;
         settle(waits[c]);
      end
      summarize();
   end
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
endmodule
